/* File: logic/pfs_pkg.sv */
/*
  Constants, types and register map of the foldback and fault sequencer.
  Assumes a 10 MHz reference clock and feedback levels given in millivolts.
*/
// Contract
// R1 - Feedback below 1.5 V starts frequency foldback
// R2 - Setpoint tracks feedback, frozen 250 mV below 1.05 V
// R3 - Frequency falls to 26 kHz at 350 mV
// R4 - Lower demand at minimum frequency skips pulses
// R5 - Early variant reaches minimum frequency at 1.5 V
// R6 - Overload flag starts countdown timer
// R7 - Overload beyond 100 ms stops gate pulses
// R8 - Restart at start threshold, recheck fault
// R9 - Persisting fault hiccups again, cleared fault resumes
// R10 - Soft-start on every restart after fault
// R11 - Compensation ramp only during on-time
// R12 - Duty limited 80%, ramp 2.5 V there
// R13 - Latched off until supply fully cycled
// R14 - Protection pin compared against 3 V
// R15 - Ignore comparator 1 us after turn-off
// R16 - Accept assertions lasting at least 600 ns
// R17 - Latch off after 4 successive events
// R18 - Off-time level on 4 consecutive cycles latches
// R19 - Supply over 25.5 V stops, latches or recovers
// R20 - Clean switching cycle clears event counter
// R21 - Fault deassertion clears overload timer
package pfs_pkg;
    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_HZ = 10_000_000;
    localparam int FSW_NOM_HZ = 65_000;
    localparam int FSW_MIN_HZ = 26_000;
    localparam logic [8:0] PER_NOM = 9'(CLK_HZ / FSW_NOM_HZ);
    localparam logic [8:0] PER_MIN = 9'(CLK_HZ / FSW_MIN_HZ);
    localparam int DMAX_PCT = 80;
    localparam int BLANK_NS = 1000;
    localparam int MINW_NS = 600;
    localparam int BLANK_CYC = (BLANK_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int MINW_CYC = (MINW_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int OL_MS = 100;
    localparam int OVP_EVENTS = 4;
    // ----------------------------------------------------------------
    // Levels in millivolts
    // ----------------------------------------------------------------
    localparam logic [11:0] FOLD_MV = 12'h5dc;
    localparam logic [11:0] FREEZE_MV = 12'h41a;
    localparam logic [11:0] FMIN_MV = 12'h15e;
    localparam logic [11:0] SKIP_MV = 12'h12c;
    localparam logic [9:0] SETPT_MAX_MV = 10'h320;
    localparam logic [9:0] SETPT_FROZEN_MV = 10'h0fa;
    localparam logic [11:0] RAMP_PEAK_MV = 12'h9c4;
    localparam logic [11:0] RAMP_STEP_MV =
        12'(int'(RAMP_PEAK_MV) / (int'(PER_NOM) * DMAX_PCT / 100));
    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    localparam logic [11:0] REG_CTRL = 12'h000;
    localparam logic [11:0] REG_STATUS = 12'h004;
    localparam logic [11:0] REG_PERIOD = 12'h008;
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_EARLY_BIT = 1;
    localparam int CTRL_VAUTO_BIT = 2;
    localparam logic [2:0] CTRL_RST = 3'h1;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic vcc_auto;
        logic early_fold;
        logic enable;
    } pfs_ctrl_t;

    typedef enum logic [1:0] {
        ST_SOFT = 2'b00,
        ST_RUN = 2'b01,
        ST_HICCUP = 2'b10,
        ST_LATCH = 2'b11
    } pfs_state_t;
endpackage : pfs_pkg

/* File: logic/pfs_ovp_qual.sv */
/*
  Over-voltage event qualifier: blanking, minimum width, successive count.
  Assumes a comparator output that is high while the pin exceeds 3 V.
*/
`timescale 1ns/1ps
module pfs_ovp_qual import pfs_pkg::*; (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic off_edge_i,
    input wire logic off_time_i,
    input wire logic cyc_end_i,
    input wire logic protection_sense_pin_i,
    output logic [2:0] count_o,
    output logic latch_o
);
    logic [3:0] blank_reg;
    logic [2:0] width_reg;
    logic seen_reg;
    logic [2:0] count_reg;
    logic latch_reg;
    // ----------------------------------------------------------------
    // Qualification
    // ----------------------------------------------------------------
    wire sample_w = off_time_i && !off_edge_i && blank_reg == 4'h0; // [R15]
    wire high_w = sample_w && protection_sense_pin_i; // [R14]
    wire hit_w = high_w && width_reg == 3'(MINW_CYC - 1); // [R16]
    wire evt_w = seen_reg || hit_w;
    wire [2:0] count_next = evt_w ? 3'(count_reg + 3'h1) : 3'h0; // [R17] [R20]
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            blank_reg <= 4'h0;
            width_reg <= 3'h0;
        end else if (ce_i) begin
            if (off_edge_i) begin
                blank_reg <= 4'(BLANK_CYC); // [R15]
            end else if (blank_reg != 4'h0) begin
                blank_reg <= blank_reg - 4'h1;
            end
            // Short assertions restart the width count
            width_reg <= (high_w && !hit_w) ? width_reg + 3'h1 : 3'h0; // [R16]
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            seen_reg <= 1'b0;
            count_reg <= 3'h0;
            latch_reg <= 1'b0;
        end else if (ce_i) begin
            // A hit in the closing cycle still counts
            seen_reg <= cyc_end_i ? 1'b0 : evt_w;
            if (cyc_end_i && count_reg != 3'(OVP_EVENTS)) begin
                count_reg <= count_next; // [R18]
            end
            latch_reg <= latch_reg || count_reg == 3'(OVP_EVENTS); // [R17]
        end
    end

    assign count_o = count_reg;
    assign latch_o = latch_reg;
    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    AST_BLANK_IGNORED: assert property (blank_reg != 4'h0 |-> !hit_w) // [R15]
        else $error("Comparator sampled inside blanking");
    AST_BLANK_LOAD: assert property (ce_i && off_edge_i |=> blank_reg == 4'(BLANK_CYC)) // [R15]
        else $error("Blanking not started at turn-off");
    AST_MIN_WIDTH: assert property ($rose(seen_reg) |-> $past(width_reg) == 3'(MINW_CYC - 1)) // [R16]
        else $error("Event accepted below minimum width");
    AST_FOUR_EVENTS: assert property ($rose(latch_reg) |-> $past(count_reg) == 3'(OVP_EVENTS)) // [R17]
        else $error("Latch without four successive events");
    AST_CLEAN_CLEARS: assert property (ce_i && cyc_end_i && !evt_w && !latch_reg |=> count_reg == 3'h0) // [R20]
        else $error("Event counter not cleared by clean cycle");
endmodule : pfs_ovp_qual

/* File: logic/pfs_sequencer.sv */
/*
  Foldback, skip, soft-start, overload hiccup and latch-off sequencer
  with an AXI4-Lite register slave.
  Assumes comparator outputs synchronous to ref_clk_i; a supply cycle
  down and up is presented as rst_i.
*/
`timescale 1ns/1ps
module pfs_sequencer import pfs_pkg::*; #(
    parameter int OL_CYCLES = OL_MS * (CLK_HZ / 1000),
    parameter int SS_STEP_CYC = 16
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic [11:0] feedback_level_i,
    input wire logic cs_trip_i,
    input wire logic overload_i,
    input wire logic supply_start_threshold_i,
    input wire logic vcc_ovp_i,
    input wire logic protection_sense_pin_i,
    output logic gate_o,
    output logic [11:0] ramp_o,
    output logic [9:0] setpoint_o,
    output logic latch_hold_element_o,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // ----------------------------------------------------------------
    // Functions
    // ----------------------------------------------------------------
    function automatic logic pfs_hit(input logic [11:0] a, input logic [11:0] off);
        pfs_hit = a[11:2] == off[11:2];
    endfunction : pfs_hit

    function automatic logic pfs_mapped(input logic [11:0] a);
        pfs_mapped = pfs_hit(a, REG_CTRL) || pfs_hit(a, REG_STATUS) || pfs_hit(a, REG_PERIOD);
    endfunction : pfs_mapped

    function automatic logic [8:0] pfs_period(input logic [11:0] fb, input logic early);
        int span;
        span = int'(FOLD_MV) - int'(fb);
        if (fb >= FOLD_MV) begin
            pfs_period = PER_NOM;
        end else if (early || fb <= FMIN_MV) begin
            pfs_period = PER_MIN;
        end else begin
            pfs_period = 9'(int'(PER_NOM) + span * int'(PER_MIN - PER_NOM)
                            / int'(FOLD_MV - FMIN_MV));
        end
    endfunction : pfs_period

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    pfs_state_t state_reg;
    pfs_state_t state_next;
    pfs_ctrl_t ctrl_reg;
    logic [8:0] cyc_reg;
    logic [8:0] period_reg;
    logic [8:0] maxon_reg;
    logic on_reg;
    logic [11:0] ramp_reg;
    logic [9:0] setpoint_reg;
    logic [7:0] ss_reg;
    logic [15:0] ss_div_reg;
    logic [19:0] ol_cnt_reg;
    logic hic_low_reg;
    logic [2:0] ovp_count;
    logic ovp_latch;

    // ----------------------------------------------------------------
    // Feedback decode
    // ----------------------------------------------------------------
    wire fold_w = feedback_level_i < FOLD_MV; // [R1]
    wire frozen_w = feedback_level_i < FREEZE_MV; // [R2]
    wire skip_w = feedback_level_i < SKIP_MV; // [R4]
    wire [8:0] period_calc = pfs_period(feedback_level_i, ctrl_reg.early_fold); // [R3] [R5]
    wire [8:0] maxon_calc = 9'((18'(period_calc) * 18'(DMAX_PCT)) / 18'd100); // [R12]
    wire [9:0] track_w = 10'((int'(feedback_level_i) * 10) / 42);
    wire [9:0] sp_w = frozen_w ? SETPT_FROZEN_MV : // [R2]
                      (track_w > SETPT_MAX_MV ? SETPT_MAX_MV : track_w);

    // ----------------------------------------------------------------
    // Switching cycle
    // ----------------------------------------------------------------
    wire active_w = state_reg == ST_SOFT || state_reg == ST_RUN;
    wire run_ok = active_w && ctrl_reg.enable && !vcc_ovp_i;
    wire cyc_end = cyc_reg == period_reg - 9'h1;
    wire [8:0] on_lim = state_reg == ST_SOFT ? // [R10]
        9'((18'(maxon_reg) * (18'(ss_reg) + 18'd1)) >> 8) : maxon_reg;
    wire off_hit = cs_trip_i || (10'(cyc_reg) + 10'h1) >= {1'b0, on_lim}; // [R12]
    wire on_next = cyc_end ? (run_ok && !skip_w) : (on_reg && !off_hit && run_ok); // [R4]
    wire off_edge = on_reg && !on_next;
    wire [12:0] ramp_sum = 13'(ramp_reg) + 13'(RAMP_STEP_MV);
    wire [11:0] ramp_sat = ramp_sum > 13'(RAMP_PEAK_MV) ? RAMP_PEAK_MV : ramp_sum[11:0];
    wire [11:0] ramp_next = (on_next && on_reg) ? ramp_sat : 12'h000; // [R11]

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            cyc_reg <= 9'h000;
            period_reg <= PER_NOM;
            maxon_reg <= 9'h000;
        end else if (ce_i) begin
            cyc_reg <= cyc_end ? 9'h000 : cyc_reg + 9'h001;
            if (cyc_end) begin
                period_reg <= period_calc; // [R1] [R3]
                maxon_reg <= maxon_calc; // [R12]
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            on_reg <= 1'b0;
            ramp_reg <= 12'h000;
            setpoint_reg <= SETPT_FROZEN_MV;
        end else if (ce_i) begin
            on_reg <= on_next;
            ramp_reg <= ramp_next; // [R11]
            setpoint_reg <= sp_w; // [R2]
        end
    end

    // Supply overvoltage blocks the drive without waiting for a clock
    assign gate_o = on_reg && run_ok; // [R7] [R19]
    assign ramp_o = ramp_reg;
    assign setpoint_o = setpoint_reg;
    assign latch_hold_element_o = state_reg == ST_LATCH; // [R13]

    // ----------------------------------------------------------------
    // Soft-start and overload timer
    // ----------------------------------------------------------------
    wire ss_tick = ss_div_reg == 16'(SS_STEP_CYC - 1);
    wire ol_count = overload_i && active_w; // [R6]
    wire ol_expire = ol_count && ol_cnt_reg == 20'(OL_CYCLES - 1); // [R7]

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            ss_reg <= 8'h00;
            ss_div_reg <= 16'h0000;
            ol_cnt_reg <= 20'h00000;
            hic_low_reg <= 1'b0;
        end else if (ce_i) begin
            ss_div_reg <= (state_reg != ST_SOFT || ss_tick) ? 16'h0000 : ss_div_reg + 16'h0001;
            if (state_reg != ST_SOFT) begin
                ss_reg <= 8'h00; // [R10]
            end else if (ss_tick && ss_reg != 8'hff) begin
                ss_reg <= ss_reg + 8'h01;
            end
            ol_cnt_reg <= ol_count ? ol_cnt_reg + 20'h00001 : 20'h00000; // [R6] [R21]
            // Restart only after the supply has sagged and recharged
            hic_low_reg <= state_reg == ST_HICCUP && (hic_low_reg || !supply_start_threshold_i);
        end
    end

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_SOFT: begin
                if (ss_reg == 8'hff) begin
                    state_next = ST_RUN;
                end
            end
            ST_RUN: begin
                state_next = ST_RUN;
            end
            ST_HICCUP: begin
                if (hic_low_reg && supply_start_threshold_i) begin
                    state_next = ST_SOFT; // [R8] [R10]
                end
            end
            ST_LATCH: begin
                state_next = ST_LATCH; // [R13]
            end
            default: begin
                state_next = ST_LATCH;
            end
        endcase
        if (active_w && ol_expire) begin
            state_next = ST_HICCUP; // [R7] [R9]
        end
        if (state_reg != ST_LATCH && vcc_ovp_i && ctrl_reg.vcc_auto) begin
            state_next = ST_HICCUP; // [R19]
        end
        if (ovp_latch || (vcc_ovp_i && !ctrl_reg.vcc_auto)) begin
            state_next = ST_LATCH; // [R17] [R19]
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            state_reg <= ST_SOFT;
        end else if (ce_i) begin
            state_reg <= state_next;
        end
    end

    pfs_ovp_qual u_ovp (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .off_edge_i(off_edge),
        .off_time_i(!on_reg),
        .cyc_end_i(cyc_end),
        .protection_sense_pin_i(protection_sense_pin_i), // [R14]
        .count_o(ovp_count),
        .latch_o(ovp_latch)
    );

    // ----------------------------------------------------------------
    // AXI4-Lite slave
    // ----------------------------------------------------------------
    logic aw_full_reg;
    logic w_full_reg;
    logic [11:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic rvalid_reg;
    logic [1:0] rresp_reg;
    logic [31:0] rdata_reg;

    // Ready falls with the clock enable so no beat is lost while frozen
    assign s_axi_awready = ce_i && !aw_full_reg;
    assign s_axi_wready = ce_i && !w_full_reg;
    assign s_axi_arready = ce_i && !rvalid_reg;
    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take = s_axi_wvalid && s_axi_wready;
    wire do_wr = aw_full_reg && w_full_reg && !bvalid_reg;
    wire ctrl_wr = do_wr && pfs_hit(awaddr_reg, REG_CTRL) && wstrb_reg[0];
    wire [31:0] status_w = {24'h000000, ovp_count, skip_w, frozen_w, fold_w, state_reg};
    wire [31:0] rd_mux =
        pfs_hit(s_axi_araddr, REG_CTRL) ? {29'h00000000, ctrl_reg} :
        pfs_hit(s_axi_araddr, REG_STATUS) ? status_w :
        pfs_hit(s_axi_araddr, REG_PERIOD) ? {23'h000000, period_reg} : 32'h00000000;

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            awaddr_reg <= 12'h000;
            wdata_reg <= 32'h00000000;
            wstrb_reg <= 4'h0;
        end else if (ce_i) begin
            if (aw_take) begin
                awaddr_reg <= s_axi_awaddr;
            end
            if (w_take) begin
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end
            aw_full_reg <= do_wr ? 1'b0 : (aw_full_reg || aw_take);
            w_full_reg <= do_wr ? 1'b0 : (w_full_reg || w_take);
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
            rvalid_reg <= 1'b0;
            rresp_reg <= RESP_OKAY;
            rdata_reg <= 32'h00000000;
            ctrl_reg <= CTRL_RST;
        end else if (ce_i) begin
            if (ctrl_wr) begin
                ctrl_reg <= wdata_reg[2:0];
            end
            if (do_wr) begin
                bvalid_reg <= 1'b1;
                bresp_reg <= pfs_mapped(awaddr_reg) ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_reg <= 1'b0;
            end
            if (s_axi_arvalid && s_axi_arready) begin
                rvalid_reg <= 1'b1;
                rdata_reg <= rd_mux;
                rresp_reg <= pfs_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rready) begin
                rvalid_reg <= 1'b0;
            end
        end
    end

    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rresp = rresp_reg;
    assign s_axi_rdata = rdata_reg;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    AST_FOLD_SLOWS: assert property (ce_i && cyc_end && frozen_w |=> period_reg > PER_NOM) // [R1]
        else $error("Foldback did not lower frequency");
    AST_SETPT_FROZEN: assert property (ce_i && frozen_w |=> setpoint_o == SETPT_FROZEN_MV) // [R2]
        else $error("Setpoint not frozen at light load");
    AST_MIN_FREQ: assert property (ce_i && cyc_end && feedback_level_i <= FMIN_MV
                                   |=> period_reg == PER_MIN) // [R3]
        else $error("Minimum frequency not reached");
    AST_SKIP: assert property (ce_i && cyc_end && skip_w |=> !gate_o) // [R4]
        else $error("Pulse issued during skip");
    AST_EARLY_FOLD: assert property (ce_i && cyc_end && fold_w && ctrl_reg.early_fold
                                     |=> period_reg == PER_MIN) // [R5]
        else $error("Early foldback not at minimum frequency");
    AST_OL_TIMER_CLR: assert property (ce_i && !overload_i |=> ol_cnt_reg == 20'h00000) // [R21]
        else $error("Overload timer not cleared");
    AST_HICCUP_STOP: assert property (state_reg == ST_HICCUP |-> !gate_o) // [R7]
        else $error("Gate active during hiccup");
    AST_RESTART_SOFT: assert property (state_reg == ST_HICCUP ##1 state_reg == ST_SOFT
                                       |-> ss_reg == 8'h00 ##1 state_reg != ST_RUN) // [R10]
        else $error("Restart without soft-start");
    AST_RAMP_ON_ONLY: assert property (!on_reg |-> ramp_o == 12'h000) // [R11]
        else $error("Ramp present during off-time");
    AST_DUTY_LIMIT: assert property (on_reg |-> cyc_reg < maxon_reg) // [R12]
        else $error("Duty limit exceeded");
    AST_LATCH_HOLD: assert property (state_reg == ST_LATCH |=> state_reg == ST_LATCH
                                     && latch_hold_element_o) // [R13]
        else $error("Latched state released");
    AST_VCC_OVP: assert property (vcc_ovp_i |-> !gate_o) // [R19]
        else $error("Gate active under supply overvoltage");
    CVR_HICCUP: cover property (state_reg == ST_RUN ##1 state_reg == ST_HICCUP);
    CVR_RESUME: cover property (state_reg == ST_SOFT ##1 state_reg == ST_RUN);
    CVR_LATCH: cover property (ovp_latch ##1 state_reg == ST_LATCH);
endmodule : pfs_sequencer

/* File: bench/pfs_partner.sv */
/*
  Power stage model: trips the current-sense comparator after a set on-time.
  Assumes gate_i comes from the sequencer and trip_i stays under 256 clocks.
*/
`timescale 1ns/1ps
module pfs_partner (
    input wire logic ref_clk_i,
    input wire logic gate_i,
    input wire logic [7:0] trip_i,
    output logic cs_trip_o
);
    // ----------------------------------------------------------------
    // Primary current rises only while the switch conducts
    // ----------------------------------------------------------------
    logic [7:0] on_reg;
    always_ff @(posedge ref_clk_i) begin
        on_reg <= gate_i ? on_reg + 8'h01 : 8'h00;
    end
    // Low outside on-time, like the real comparator with no current
    assign cs_trip_o = gate_i && (on_reg >= trip_i);
endmodule : pfs_partner

/* File: bench/pfs_sequencer_tb.sv */
/*
  Self-checking bench for the foldback and fault sequencer.
  Assumes short overload and soft-start counts set through parameters.
*/
`timescale 1ns/1ps
module pfs_sequencer_tb import pfs_pkg::*;;
    // ----------------------------------------------------------------
    // Stimulus, design and partner
    // ----------------------------------------------------------------
    logic ref_clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, cs_trip_i, overload_i = 1'b0;
    logic supply_start_threshold_i = 1'b1, vcc_ovp_i = 1'b0, protection_sense_pin_i = 1'b0;
    logic [11:0] feedback_level_i = 12'h7d0, s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
    logic s_axi_arready, s_axi_bvalid, s_axi_rvalid, gate_o, latch_hold_element_o;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic [11:0] ramp_o;
    logic [9:0] setpoint_o;
    logic [7:0] trip_lim = 8'hff;
    int fail_count = 0, comparisons = 0, hi, bad;
    pfs_sequencer #(.OL_CYCLES(200), .SS_STEP_CYC(1)) dut (.*);
    pfs_partner u_stage (.ref_clk_i(ref_clk_i), .gate_i(gate_o), .trip_i(trip_lim),
        .cs_trip_o(cs_trip_i));
    initial begin
        forever #50 ref_clk_i = ~ref_clk_i;
    end
    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask : cyc
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Readies are combinational, so they are sampled mid-cycle
    task automatic rd(input logic [11:0] a, output logic [31:0] q);
        logic h;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin @(negedge ref_clk_i); h = s_axi_arready; @(posedge ref_clk_i); end while (!h);
        s_axi_arvalid <= 1'b0;
        do begin @(negedge ref_clk_i); h = s_axi_rvalid; @(posedge ref_clk_i); end while (!h);
        q = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : rd
    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        logic pa = 1'b1, pw = 1'b1, h;
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (pa | pw) begin
            @(negedge ref_clk_i);
            h = s_axi_awready;
            pw = pw & !s_axi_wready;
            @(posedge ref_clk_i);
            pa = pa & !h;
            s_axi_awvalid <= pa;
            s_axi_wvalid <= pw;
        end
        do begin @(negedge ref_clk_i); h = s_axi_bvalid; @(posedge ref_clk_i); end while (!h);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : wr
    // Longest gate run and ramp seen while the gate is low
    task automatic watch(input int n);
        int run;
        run = 0;
        hi = 0;
        bad = 0;
        repeat (n) begin
            @(negedge ref_clk_i);
            run = (gate_o === 1'b1) ? run + 1 : 0;
            hi = (run > hi) ? run : hi;
            bad += (gate_o !== 1'b1 && ramp_o !== 12'h000);
        end
    endtask : watch
    task automatic supply_cycle();
        supply_start_threshold_i <= 1'b0;
        cyc(5);
        supply_start_threshold_i <= 1'b1;
        cyc(2);
    endtask : supply_cycle
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_fold();
        rd(REG_CTRL, d);
        chk(d, 32'(CTRL_RST));
        wr(12'h00c, 32'h7);
        chk(resp, RESP_SLVERR);
        rd(12'h00c, d);
        chk(resp, RESP_SLVERR);
        cyc(600);
        rd(REG_PERIOD, d);
        chk(d, 32'(PER_NOM));
        watch(600);
        chk(hi, int'(PER_NOM) * DMAX_PCT / 100);
        chk(bad, 0);
        chk(setpoint_o, 10'(2000 * 10 / 42));
        feedback_level_i <= 12'h320;
        cyc(500);
        chk(setpoint_o, SETPT_FROZEN_MV);
        feedback_level_i <= FMIN_MV;
        cyc(800);
        rd(REG_PERIOD, d);
        chk(d, 32'(PER_MIN));
        feedback_level_i <= 12'h0c8;
        cyc(400);
        watch(800);
        chk(hi, 0);
        feedback_level_i <= 12'h3e8;
        wr(REG_CTRL, 32'h3);
        cyc(800);
        rd(REG_PERIOD, d);
        chk(d, 32'(PER_MIN));
        wr(REG_CTRL, 32'h1);
        $display("fold test done");
    endtask : t_fold
    task automatic t_overload();
        feedback_level_i <= 12'h7d0;
        trip_lim <= 8'h3c;
        overload_i <= 1'b1;
        cyc(150);
        overload_i <= 1'b0;
        cyc(10);
        overload_i <= 1'b1;
        cyc(150);
        rd(REG_STATUS, d);
        chk(d[1:0], ST_RUN);
        cyc(100);
        rd(REG_STATUS, d);
        chk(d[1:0], ST_HICCUP);
        watch(200);
        chk(hi, 0);
        supply_cycle();
        rd(REG_STATUS, d);
        chk(d[1:0], ST_SOFT);
        cyc(700);
        rd(REG_STATUS, d);
        chk(d[1:0], ST_HICCUP);
        overload_i <= 1'b0;
        supply_cycle();
        cyc(600);
        rd(REG_STATUS, d);
        chk(d[1:0], ST_RUN);
        $display("overload test done");
    endtask : t_overload
    task automatic t_latch();
        protection_sense_pin_i <= 1'b1;
        for (int i = 0; i < 3000 && latch_hold_element_o !== 1'b1; i++) cyc(1);
        chk(latch_hold_element_o, 1'b1);
        protection_sense_pin_i <= 1'b0;
        supply_cycle();
        watch(300);
        chk(hi, 0);
        chk(latch_hold_element_o, 1'b1);
        rst_i <= 1'b1;
        cyc(2);
        rst_i <= 1'b0;
        cyc(600);
        chk(latch_hold_element_o, 1'b0);
        wr(REG_CTRL, 32'h5);
        vcc_ovp_i <= 1'b1;
        cyc(3);
        chk(latch_hold_element_o, 1'b0);
        chk(gate_o, 1'b0);
        wr(REG_CTRL, 32'h1);
        cyc(1);
        chk(latch_hold_element_o, 1'b1);
        vcc_ovp_i <= 1'b0;
        $display("latch test done");
    endtask : t_latch
    // ----------------------------------------------------------------
    // Sequence, watchdog and verdict
    // ----------------------------------------------------------------
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_of_test
    initial begin
        cyc(16);
        rst_i <= 1'b0;
        cyc(1);
        t_fold();
        t_overload();
        t_latch();
        end_of_test();
    end
    initial begin
        cyc(40000);
        fail_count++;
        end_of_test();
    end
endmodule : pfs_sequencer_tb
